/* File: verilog/clkdrv_pkg.sv */
// Shared constants and types for the clock driver output control block
// Function
// - Reference select low picks A, high B
// - Bank stop control high halts bank synchronously
// - Gated stop holds levels set by edge select
// - Tri-state stop floats both bank outputs
// - Outputs follow falling or rising reference edge
// - Undriven edge select reads as high
// - Bypass passes selected reference straight to outputs
// - Sleep disables inputs and stops all switching
// - Gated sleep holds all outputs by edge select
// - Tri-state sleep floats all bank and feedback outputs
// - Input standard: high 2.5V, mid 1.8V, low differential
// - Three three-level pins pick each bank setting
// - Two three-level pins pick feedback divide
// - VCO range select chooses oscillator circuit
// - Undriven three-level input reads as mid
`default_nettype none
package clkdrv_pkg;
  // Bank count and APB geometry
  localparam int NUM_BANKS = 5;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h04;
  localparam logic [ADDR_W-1:0] BANK_SKEW_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] FB_CFG_OFS    = 8'h0c;

  // Control field positions
  localparam int CTRL_REF_SEL_BIT = 0;
  localparam int CTRL_STYLE_BIT   = 1;
  localparam int CTRL_EDGE_BIT    = 2;
  localparam int CTRL_BYPASS_BIT  = 3;
  localparam int CTRL_SLEEP_N_BIT = 4;
  localparam int CTRL_VCO_BIT     = 5;
  localparam int CTRL_STOP_LSB    = 8;

  // Status and feedback config field positions
  localparam int STAT_RUN_LSB   = 0;
  localparam int STAT_FB_RUN    = 5;
  localparam int STAT_ASLEEP    = 6;
  localparam int STAT_REF_SEL   = 7;
  localparam int STAT_STD_LSB   = 8;
  localparam int STAT_VCO_BIT   = 10;
  localparam int FB_SKEW_LSB    = 0;
  localparam int FB_DIV_LSB     = 6;
  localparam int FB_OUTSTD_LSB  = 10;

  // Reset values: edge select reads high when nobody drives it
  localparam logic CTRL_EDGE_RST    = 1'b1;
  localparam logic CTRL_SLEEP_N_RST = 1'b1;

  // Resolved three-level pin state
  typedef enum logic [1:0] {TRI_LOW = 2'h0, TRI_MID = 2'h1, TRI_HIGH = 2'h2} tri_t;

  // Decoded input standard
  typedef enum logic [1:0] {STD_DIFF = 2'h0, STD_SE_1V8 = 2'h1, STD_SE_2V5 = 2'h2} in_std_t;

  // Software control word
  typedef struct packed {
    logic [NUM_BANKS-1:0] bank_stop_n;
    logic                 vco_range_select;
    logic                 sleep_n;
    logic                 loop_bypass;
    logic                 edge_polarity_select;
    logic                 stop_style_select;
    logic                 ref_source_select;
  } ctrl_t;

  // APB request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;
endpackage
`default_nettype wire

/* File: verilog/tri_level_resolve.sv */
// Synchroniser and resolver for a group of three-level pins
`timescale 1ns/1ps
`default_nettype none
module tri_level_resolve #(
  parameter int N = 2
) (
  // Clock, reset, enable
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    ce_in,
  // Pin level and undriven flag per pin
  input  wire logic [N-1:0]            level_in,
  input  wire logic [N-1:0]            float_in,
  // Resolved state per pin
  output var  clkdrv_pkg::tri_t [N-1:0] state_out
);
  import clkdrv_pkg::*;

  logic [N-1:0] lvl_meta;   // First stage, read only by second
  logic [N-1:0] lvl_sync;   // Second stage
  logic [N-1:0] flt_meta;   // First stage, read only by second
  logic [N-1:0] flt_sync;   // Second stage

  // Two-flop synchronisers for the pin pairs
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lvl_meta <= '0;
      lvl_sync <= '0;
      flt_meta <= '1;
      flt_sync <= '1;
    end else if (ce_in) begin
      lvl_meta <= level_in;
      lvl_sync <= lvl_meta;
      flt_meta <= float_in;
      flt_sync <= flt_meta;
    end
  end

  // Exactly one of three states per pin; undriven wins over level
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < N; i++) begin
        state_out[i] <= TRI_MID;
      end
    end else if (ce_in) begin
      for (int i = 0; i < N; i++) begin
        if (flt_sync[i]) begin
          state_out[i] <= TRI_MID;
        end else if (lvl_sync[i]) begin
          state_out[i] <= TRI_HIGH;
        end else begin
          state_out[i] <= TRI_LOW;
        end
      end
    end
  end

  // A floating pin resolves to mid one edge later
  chk_float_mid: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ce_in && flt_sync[0] |=> state_out[0] == TRI_MID)
    else $error("floating pin not resolved to mid");
endmodule
`default_nettype wire

/* File: verilog/clock_driver_output_control.sv */
// Output gating, stop, sleep and mode decode of the clock driver
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module clock_driver_output_control (
  // Clock, reset, enable
  input  wire logic                                   clk_in,
  input  wire logic                                   sys_rst_in,
  input  wire logic                                   ce_in,
  // APB slave
  input  wire clkdrv_pkg::apb_req_t                   apb_req_in,
  output var  clkdrv_pkg::apb_rsp_t                   apb_rsp_out,
  // Reference clock pins
  input  wire logic                                   ref_clock_a_in,
  input  wire logic                                   ref_clock_b_in,
  // Three-level pins: level and undriven flag
  input  wire logic                                   input_standard_select_in,
  input  wire logic                                   input_standard_float_in,
  input  wire logic                                   output_standard_select_in,
  input  wire logic                                   output_standard_float_in,
  input  wire logic [3*clkdrv_pkg::NUM_BANKS-1:0]     bank_skew_select_in,
  input  wire logic [3*clkdrv_pkg::NUM_BANKS-1:0]     bank_skew_float_in,
  input  wire logic [2:0]                             feedback_skew_select_in,
  input  wire logic [2:0]                             feedback_skew_float_in,
  input  wire logic [1:0]                             feedback_divide_select_in,
  input  wire logic [1:0]                             feedback_divide_float_in,
  // Bank clock pins with output enables
  output logic [clkdrv_pkg::NUM_BANKS-1:0]            bank_clk_out,
  output logic [clkdrv_pkg::NUM_BANKS-1:0]            bank_clk_n_out,
  output logic [clkdrv_pkg::NUM_BANKS-1:0]            bank_oe_out,
  // Feedback clock pins with output enable
  output logic                                        feedback_clk_out,
  output logic                                        feedback_clk_n_out,
  output logic                                        feedback_oe_out,
  // Decoded static modes for the analog side
  output var  clkdrv_pkg::in_std_t                    input_standard_out,
  output var  clkdrv_pkg::tri_t [1:0]                 feedback_divide_out,
  output logic                                        vco_range_out,
  output logic                                        pll_bypass_out
);
  import clkdrv_pkg::*;

  ctrl_t                   ctrl;        // Software control word
  logic [1:0]              ref_meta;    // First sync stage, A and B
  logic [1:0]              ref_sync;    // Second sync stage
  logic [1:0]              ref_prev;    // Delayed copy for edge finding
  logic                    ref_cur;     // Selected reference, now
  logic                    ref_old;     // Selected reference, one cycle ago
  logic                    sel_edge;    // Selected edge seen this cycle
  logic                    asleep;      // Sleep in force
  logic [NUM_BANKS-1:0]    run;         // Bank running after sync stop
  logic                    src_lvl;     // Level driven by running banks
  logic                    hold_true;   // Gated level of true outputs
  logic [NUM_BANKS-1:0]    next_true;
  logic [NUM_BANKS-1:0]    next_comp;
  logic [NUM_BANKS-1:0]    next_oe;
  logic                    next_fb_true;
  logic                    next_fb_comp;
  logic                    next_fb_oe;
  tri_t [1:0]              std_tri;     // Input and output standard pins
  tri_t [3*NUM_BANKS-1:0]  bank_tri;    // Bank setting pins
  tri_t [2:0]              fb_tri;      // Feedback setting pins
  tri_t [1:0]              div_tri;     // Feedback divide pins
  logic                    apb_setup;   // Setup phase of a new transfer
  logic                    apb_wr;      // Write completes this edge
  logic [DATA_W-1:0]       rd_word;     // Read mux result
  logic                    rd_ok;       // Address is mapped

  // Three-level pin groups
  tri_level_resolve #(.N(2)) u_std (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in     (ce_in),
    .level_in  ({output_standard_select_in, input_standard_select_in}),
    .float_in  ({output_standard_float_in, input_standard_float_in}),
    .state_out (std_tri)
  );
  tri_level_resolve #(.N(3*NUM_BANKS)) u_bank (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in     (ce_in),
    .level_in  (bank_skew_select_in),
    .float_in  (bank_skew_float_in),
    .state_out (bank_tri)
  );
  tri_level_resolve #(.N(3)) u_fb (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in     (ce_in),
    .level_in  (feedback_skew_select_in),
    .float_in  (feedback_skew_float_in),
    .state_out (fb_tri)
  );
  tri_level_resolve #(.N(2)) u_div (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in     (ce_in),
    .level_in  (feedback_divide_select_in),
    .float_in  (feedback_divide_float_in),
    .state_out (div_tri)
  );

  // Reference pins cross into our clock through two flops
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ref_meta <= '0;
      ref_sync <= '0;
      ref_prev <= '0;
    end else if (ce_in && !asleep) begin
      // Inputs disabled in sleep: the pins are not even sampled
      ref_meta <= {ref_clock_b_in, ref_clock_a_in};
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  // Source pick and edge finding on the synchronised copy
  always_comb begin
    ref_cur  = ctrl.ref_source_select ? ref_sync[1] : ref_sync[0];
    ref_old  = ctrl.ref_source_select ? ref_prev[1] : ref_prev[0];
    // Rising edge when edge select high, falling when low
    if (ctrl.edge_polarity_select) begin
      sel_edge = ref_cur && !ref_old;
    end else begin
      sel_edge = !ref_cur && ref_old;
    end
    if (asleep) begin
      sel_edge = 1'b0;
    end
  end

  // Sleep follows its control bit one cycle later
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      asleep <= 1'b0;
    end else if (ce_in) begin
      asleep <= !ctrl.sleep_n;
    end
  end

  // Bank stop is taken only on a selected reference edge, on the same clock edge as the pins follow that edge; the pins show it one cycle later
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      run <= '1;
    end else if (ce_in && sel_edge) begin
      run <= ~ctrl.bank_stop_n;
    end
  end

  // Next pin values for every bank and the feedback pair
  always_comb begin
    // Bypass hands the reference through untouched
    if (ctrl.loop_bypass) begin
      src_lvl = ref_cur;
    end else begin
      // Output rise lines up with the selected reference edge
      src_lvl = ctrl.edge_polarity_select ? ref_cur : !ref_cur;
    end
    hold_true = !ctrl.edge_polarity_select;
    for (int b = 0; b < NUM_BANKS; b++) begin
      // Sleep is checked first and so beats the bank stop
      if (asleep || !run[b]) begin
        next_oe[b]   = ctrl.stop_style_select;
        next_true[b] = ctrl.stop_style_select ? hold_true : 1'b0;
        next_comp[b] = ctrl.stop_style_select ? !hold_true : 1'b0;
      end else begin
        next_oe[b]   = 1'b1;
        next_true[b] = src_lvl;
        next_comp[b] = !src_lvl;
      end
    end
    // Feedback pair has no stop of its own, only sleep
    if (asleep) begin
      next_fb_oe   = ctrl.stop_style_select;
      next_fb_true = ctrl.stop_style_select ? hold_true : 1'b0;
      next_fb_comp = ctrl.stop_style_select ? !hold_true : 1'b0;
    end else begin
      next_fb_oe   = 1'b1;
      next_fb_true = src_lvl;
      next_fb_comp = !src_lvl;
    end
  end

  // Pin flops; everything starts floating and low
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bank_clk_out       <= '0;
      bank_clk_n_out     <= '0;
      bank_oe_out        <= '0;
      feedback_clk_out   <= 1'b0;
      feedback_clk_n_out <= 1'b0;
      feedback_oe_out    <= 1'b0;
    end else if (ce_in) begin
      bank_clk_out       <= next_true;
      bank_clk_n_out     <= next_comp;
      bank_oe_out        <= next_oe;
      feedback_clk_out   <= next_fb_true;
      feedback_clk_n_out <= next_fb_comp;
      feedback_oe_out    <= next_fb_oe;
    end
  end

  // Static mode decode toward the analog side
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      input_standard_out  <= STD_SE_1V8;
      feedback_divide_out[0] <= TRI_MID;
      feedback_divide_out[1] <= TRI_MID;
      vco_range_out       <= 1'b0;
      pll_bypass_out      <= 1'b0;
    end else if (ce_in) begin
      case (std_tri[0])
        TRI_HIGH: input_standard_out <= STD_SE_2V5;
        TRI_MID:  input_standard_out <= STD_SE_1V8;
        default:  input_standard_out <= STD_DIFF;
      endcase
      feedback_divide_out <= div_tri;
      vco_range_out       <= ctrl.vco_range_select;
      pll_bypass_out      <= ctrl.loop_bypass;
    end
  end

  // APB phase decode; answer comes one cycle after setup
  assign apb_setup = apb_req_in.psel && !apb_req_in.penable && !apb_rsp_out.pready;
  assign apb_wr    = apb_req_in.psel && apb_req_in.penable && apb_rsp_out.pready
                     && apb_req_in.pwrite;

  // Read mux; setting pins appear as resolved codes, two bits per pin
  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    case (apb_req_in.paddr)
      CTRL_OFS: begin
        rd_word[CTRL_REF_SEL_BIT] = ctrl.ref_source_select;
        rd_word[CTRL_STYLE_BIT]   = ctrl.stop_style_select;
        rd_word[CTRL_EDGE_BIT]    = ctrl.edge_polarity_select;
        rd_word[CTRL_BYPASS_BIT]  = ctrl.loop_bypass;
        rd_word[CTRL_SLEEP_N_BIT] = ctrl.sleep_n;
        rd_word[CTRL_VCO_BIT]     = ctrl.vco_range_select;
        rd_word[CTRL_STOP_LSB +: NUM_BANKS] = ctrl.bank_stop_n;
      end
      STATUS_OFS: begin
        rd_word[STAT_RUN_LSB +: NUM_BANKS] = run & ~{NUM_BANKS{asleep}};
        rd_word[STAT_FB_RUN]               = !asleep;
        rd_word[STAT_ASLEEP]               = asleep;
        rd_word[STAT_REF_SEL]              = ctrl.ref_source_select;
        rd_word[STAT_STD_LSB +: 2]         = input_standard_out;
        rd_word[STAT_VCO_BIT]              = vco_range_out;
      end
      BANK_SKEW_OFS: begin
        rd_word[6*NUM_BANKS-1:0] = bank_tri;
      end
      FB_CFG_OFS: begin
        rd_word[FB_SKEW_LSB +: 6]   = fb_tri;
        rd_word[FB_DIV_LSB +: 4]    = div_tri;
        rd_word[FB_OUTSTD_LSB +: 2] = std_tri[1];
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Answer flops: zero wait states, error on unmapped address
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      apb_rsp_out <= '0;
    end else if (ce_in) begin
      apb_rsp_out.pready <= apb_setup;
      if (apb_setup) begin
        apb_rsp_out.pslverr <= !rd_ok;
        apb_rsp_out.prdata  <= apb_req_in.pwrite ? '0 : rd_word;
      end
    end
  end

  // Control register; only the control word is writable
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl                      <= '0;
      ctrl.edge_polarity_select <= CTRL_EDGE_RST;
      ctrl.sleep_n              <= CTRL_SLEEP_N_RST;
    end else if (ce_in && apb_wr && apb_req_in.paddr == CTRL_OFS) begin
      ctrl.ref_source_select    <= apb_req_in.pwdata[CTRL_REF_SEL_BIT];
      ctrl.stop_style_select    <= apb_req_in.pwdata[CTRL_STYLE_BIT];
      ctrl.edge_polarity_select <= apb_req_in.pwdata[CTRL_EDGE_BIT];
      ctrl.loop_bypass          <= apb_req_in.pwdata[CTRL_BYPASS_BIT];
      ctrl.sleep_n              <= apb_req_in.pwdata[CTRL_SLEEP_N_BIT];
      ctrl.vco_range_select     <= apb_req_in.pwdata[CTRL_VCO_BIT];
      ctrl.bank_stop_n          <= apb_req_in.pwdata[CTRL_STOP_LSB +: NUM_BANKS];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Run flags move only on a selected reference edge
  chk_stop_on_edge: assert property ($changed(run) |-> $past(sel_edge))
    else $error("bank stop changed away from selected edge");
  // Stopped levels come from edge select, not from the reference
  chk_stop_gated: assert property (
    ce_in && !asleep && !run[0] && ctrl.stop_style_select
    |=> bank_oe_out[0] && bank_clk_out[0] == !$past(ctrl.edge_polarity_select)
        && bank_clk_n_out[0] == $past(ctrl.edge_polarity_select))
    else $error("gated stop levels wrong");
  chk_stop_float: assert property (
    ce_in && !asleep && !run[0] && !ctrl.stop_style_select
    |=> !bank_oe_out[0] && !bank_clk_out[0] && !bank_clk_n_out[0])
    else $error("tri-state stop not floating");
  // Running bank follows the chosen edge one flop after sync
  chk_edge_follow: assert property (
    ce_in && !asleep && run[0] && !ctrl.loop_bypass
    |=> bank_clk_out[0] == ($past(ctrl.edge_polarity_select) ? $past(ref_cur)
        : !$past(ref_cur)))
    else $error("bank does not follow selected edge");
  chk_bypass_ref: assert property (
    ce_in && !asleep && ctrl.loop_bypass
    |=> feedback_clk_out == ($past(ctrl.ref_source_select) ? $past(ref_sync[1])
        : $past(ref_sync[0])))
    else $error("bypass does not pass selected reference");
  chk_ref_pick: assert property (
    ce_in && !asleep && run[1] && ctrl.loop_bypass && ctrl.ref_source_select
    |=> bank_clk_out[1] == $past(ref_sync[1]))
    else $error("second reference not routed to bank");
  chk_sleep_freeze: assert property (
    asleep && $past(asleep) |-> $stable(ref_sync) && $stable(run))
    else $error("switching while asleep");
  chk_sleep_gated: assert property (
    ce_in && asleep && ctrl.stop_style_select
    |=> feedback_oe_out && feedback_clk_out == !$past(ctrl.edge_polarity_select)
        && bank_clk_n_out == {NUM_BANKS{$past(ctrl.edge_polarity_select)}})
    else $error("gated sleep levels wrong");
  chk_sleep_float: assert property (
    ce_in && asleep && !ctrl.stop_style_select
    |=> bank_oe_out == '0 && !feedback_oe_out)
    else $error("tri-state sleep not floating");
  chk_sleep_priority: assert property (
    ce_in && asleep && ctrl.stop_style_select && run[0]
    |=> bank_clk_out[0] == !$past(ctrl.edge_polarity_select)
        && bank_clk_n_out[0] == $past(ctrl.edge_polarity_select))
    else $error("sleep did not override running bank");
  chk_std_high: assert property (
    ce_in && std_tri[0] == TRI_HIGH |=> input_standard_out == STD_SE_2V5)
    else $error("high standard pin not decoded");

  cov_bank_stopped: cover property (run[0] ##1 !run[0]);
  cov_sleep_entry:  cover property (!asleep ##1 asleep);
  cov_bypass_run:   cover property (ctrl.loop_bypass && sel_edge);
  cov_ref_b_edge:   cover property (ctrl.ref_source_select && sel_edge);
  cov_sleep_float:  cover property (asleep && !ctrl.stop_style_select);
endmodule
`default_nettype wire

/* File: sim/board_clock_source.sv */
// Board clock source model driving the two reference pins
`timescale 1ns/1ps
`default_nettype none
module board_clock_source #(
  parameter real HALF_NS = 16.0
) (
  // Per-source run enables
  input  wire logic run_a_in,
  input  wire logic run_b_in,
  // Reference pins
  output logic      ref_a_out,
  output logic      ref_b_out
);
  // Phase kept loose from the system clock; a stopped source sits low
  initial begin
    ref_a_out = 1'b0;
    ref_b_out = 1'b0;
    #1.3;
    forever begin
      #(HALF_NS);
      ref_a_out = run_a_in ? ~ref_a_out : 1'b0;
      ref_b_out = run_b_in ? ~ref_b_out : 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/clock_driver_output_control_tb_top.sv */
// Self-checking bench for the clock driver output control block
`timescale 1ns/1ps
`default_nettype none
module clock_driver_output_control_tb_top;
  import clkdrv_pkg::*;
  // Clock, reset, bus
  logic                   clk_in, sys_rst_in, run_a, run_b, ref_a, ref_b, err, ce;
  apb_req_t               apb_req;
  apb_rsp_t               apb_rsp;
  logic [31:0]            rd;
  // Three-level pins: level and undriven flag
  logic                   ist_lvl, ist_flt, ost_lvl, ost_flt;
  logic [3*NUM_BANKS-1:0] bsk_lvl, bsk_flt;
  logic [2:0]             fsk_lvl, fsk_flt;
  logic [1:0]             div_lvl, div_flt;
  // Pin outputs and decoded modes
  logic [NUM_BANKS-1:0]   bq, bqn, boe;
  logic                   fq, fqn, foe, vco, byp;
  in_std_t                in_std;
  tri_t [1:0]             fdiv;
  int                     num_errors, samples_checked;

  // System clock, 4 ns
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  board_clock_source i_board_clock_source (.run_a_in(run_a), .run_b_in(run_b),
    .ref_a_out(ref_a), .ref_b_out(ref_b));

  clock_driver_output_control i_clock_driver_output_control (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .ce_in(ce), .apb_req_in(apb_req), .apb_rsp_out(apb_rsp),
    .ref_clock_a_in(ref_a), .ref_clock_b_in(ref_b),
    .input_standard_select_in(ist_lvl), .input_standard_float_in(ist_flt),
    .output_standard_select_in(ost_lvl), .output_standard_float_in(ost_flt),
    .bank_skew_select_in(bsk_lvl), .bank_skew_float_in(bsk_flt),
    .feedback_skew_select_in(fsk_lvl), .feedback_skew_float_in(fsk_flt),
    .feedback_divide_select_in(div_lvl), .feedback_divide_float_in(div_flt),
    .bank_clk_out(bq), .bank_clk_n_out(bqn), .bank_oe_out(boe),
    .feedback_clk_out(fq), .feedback_clk_n_out(fqn), .feedback_oe_out(foe),
    .input_standard_out(in_std), .feedback_divide_out(fdiv),
    .vco_range_out(vco), .pll_bypass_out(byp));

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_in);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_in);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (n == 20) begin
      check("pready", 32'h0, 32'h1);
      results();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk_in);
  endtask

  // Pin triple {true, comp, oe}; index NUM_BANKS is the feedback pair
  function automatic logic [2:0] pin(input int b);
    return (b < NUM_BANKS) ? {bq[b], bqn[b], boe[b]} : {fq, fqn, foe};
  endfunction

  // Bounded wait for a pin triple that then holds past a reference period
  task automatic want_pin(input int b, input logic [2:0] exp);
    int k;
    k = 0;
    for (int n = 0; n < 60 && k < 12; n++) begin
      @(posedge clk_in);
      k = (pin(b) === exp) ? k + 1 : 0;
    end
    check($sformatf("pin %0d", b), {29'h0, pin(b)}, {29'h0, exp});
    check($sformatf("pin %0d hold", b), k, 32'hc);
  endtask

  // Clock enable low must freeze a running bank
  task automatic t_hold();
    logic [2:0] frozen;
    ce <= 1'b0;
    repeat (2) @(posedge clk_in);
    frozen = pin(1);
    repeat (16) @(posedge clk_in);
    check("ce hold", {29'h0, pin(1)}, {29'h0, frozen});
    ce <= 1'b1;
  endtask

  // Whether a bank true output shows both levels over five reference periods
  task automatic want_toggle(input int b, input logic exp);
    logic [1:0] seen;
    seen = 2'h0;
    repeat (8) @(posedge clk_in);
    repeat (40) begin
      @(posedge clk_in);
      if (bq[b] === 1'b1) seen[1] = 1'b1;
      if (bq[b] === 1'b0) seen[0] = 1'b1;
    end
    check($sformatf("toggle %0d", b), {31'h0, &seen}, {31'h0, exp});
  endtask

  // Reset value and an unmapped address
  task automatic t_regs();
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl reset", rd, 32'h14);
    check("ctrl err", {31'h0, err}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
  endtask

  // Three-level decodes, vco range and bypass
  task automatic t_modes();
    repeat (6) @(posedge clk_in);
    check("std mid", {30'h0, in_std}, {30'h0, STD_SE_1V8});
    check("div", {28'h0, fdiv}, {28'h0, TRI_HIGH, TRI_MID});
    apb(1'b0, BANK_SKEW_OFS, 32'h0);
    check("bank pins", rd, 32'h6);
    apb(1'b0, FB_CFG_OFS, 32'h0);
    check("fb pins", rd, 32'h666);
    ist_flt <= 1'b0;
    ist_lvl <= 1'b1;
    repeat (6) @(posedge clk_in);
    check("std high", {30'h0, in_std}, {30'h0, STD_SE_2V5});
    ist_lvl <= 1'b0;
    repeat (6) @(posedge clk_in);
    check("std low", {30'h0, in_std}, {30'h0, STD_DIFF});
    apb(1'b1, CTRL_OFS, 32'h3c);
    repeat (2) @(posedge clk_in);
    check("vco", {31'h0, vco}, 32'h1);
    check("bypass", {31'h0, byp}, 32'h1);
  endtask

  // Reference choice: only source A runs
  task automatic t_ref();
    want_toggle(1, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h1d);
    want_toggle(1, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h14);
    want_toggle(1, 1'b1);
  endtask

  // Bank 0 stopped in each style while bank 1 runs
  task automatic t_stop();
    apb(1'b1, CTRL_OFS, 32'h116);
    want_pin(0, 3'b011);
    want_toggle(1, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h112);
    want_pin(0, 3'b101);
    apb(1'b1, CTRL_OFS, 32'h110);
    want_pin(0, 3'b000);
    apb(1'b1, CTRL_OFS, 32'h14);
    want_toggle(0, 1'b1);
  endtask

  // Sleep in each style, with a bank stop set beside it in two of the three
  task automatic t_sleep();
    apb(1'b1, CTRL_OFS, 32'h106);
    for (int b = 0; b <= NUM_BANKS; b++) want_pin(b, 3'b011);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("status sleep", {30'h0, rd[STAT_ASLEEP], rd[STAT_FB_RUN]}, 32'h2);
    apb(1'b1, CTRL_OFS, 32'h02);
    for (int b = 0; b <= NUM_BANKS; b++) want_pin(b, 3'b101);
    apb(1'b1, CTRL_OFS, 32'h100);
    for (int b = 0; b <= NUM_BANKS; b++) want_pin(b, 3'b000);
    apb(1'b1, CTRL_OFS, 32'h14);
    want_toggle(2, 1'b1);
  endtask

  // Main sequence; three-level pins move only inside t_modes
  initial begin
    num_errors = 0;
    samples_checked = 0;
    sys_rst_in = 1'b1;
    ce = 1'b1;
    apb_req = '0;
    run_a = 1'b1;
    run_b = 1'b0;
    {ist_lvl, ist_flt, ost_lvl, ost_flt} = 4'b0101;
    {bsk_lvl, bsk_flt} = {15'h1, 15'h2};
    {fsk_lvl, fsk_flt, div_lvl, div_flt} = {3'h5, 3'h2, 2'b10, 2'b01};
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_modes();
    t_ref();
    t_hold();
    t_stop();
    t_sleep();
    results();
  end
endmodule
`default_nettype wire
